// file: rtl/capacitive_sense_scheduler.sv
// capacitive sense scheduler: rate control, slot sequencer, tuning, output gating
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "css_params.svh"

module css_capacitive_sense_scheduler
   import css_pkg::*;
#(
   parameter int unsigned PERIOD_FAST_CYC = `CSS_PERIOD_FAST_MS * `CSS_CYC_PER_MS,
   parameter int unsigned PERIOD_NORMAL_CYC = `CSS_PERIOD_NORMAL_MS * `CSS_CYC_PER_MS,
   parameter int unsigned PERIOD_SLOW1_CYC = `CSS_PERIOD_SLOW1_MS * `CSS_CYC_PER_MS,
   parameter int unsigned PERIOD_SLOW2_CYC = `CSS_PERIOD_SLOW2_MS * `CSS_CYC_PER_MS,
   parameter int unsigned HOLD_CYC = `CSS_HOLD_S * `CSS_CYC_PER_S,
   parameter int unsigned TUNE_DELAY_CYC = `CSS_TUNE_DELAY_S * `CSS_CYC_PER_S
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // conversion front end
   output logic conv_req_o,
   output logic [1:0] conv_ch_o,
   output logic join_sw_o,
   input wire logic conv_done_i,
   input wire logic [15:0] count_i,
   output logic [29:0] tune_o,
   // detector and noise inputs
   input wire logic suspect_i,
   input wire logic prox_det_i,
   input wire logic [1:0] touch_det_i,
   input wire logic noise_i,
   // direct outputs
   output logic prox_o,
   output logic prox_oe_o,
   output logic [1:0] touch_o,
   output logic [1:0] touch_oe_o,
   output logic fast_o,
   output logic tuning_o
);

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   css_state_s st_q;
   css_state_s st_d;

   // active period length for a rate code
   function automatic logic [31:0] period_of(input logic [1:0] code);
      logic [31:0] p;
      p = 32'(PERIOD_FAST_CYC);
      case (code)
         CSS_FAST_RATE_MODE: p = 32'(PERIOD_FAST_CYC);
         CSS_NORMAL_RATE_MODE: p = 32'(PERIOD_NORMAL_CYC);
         CSS_SLOW_RATE_MODE_ONE: p = 32'(PERIOD_SLOW1_CYC);
         CSS_SLOW_RATE_MODE_TWO: p = 32'(PERIOD_SLOW2_CYC);
         default: p = 32'(PERIOD_FAST_CYC);
      endcase
      return p;
   endfunction : period_of

   // one tuning step: counts high add fine compensation, carry into the coarse step
   function automatic css_tune_s tune_step(input css_tune_s t, input logic hi);
      css_tune_s r;
      r = t;
      if (hi) begin
         if (t.comp != 6'h3F) begin
            r.comp = t.comp + 6'h01;
         end else if (t.mult != 4'hF) begin
            r.mult = t.mult + 4'h1;
            r.comp = 6'h00;
         end
      end else begin
         if (t.comp != 6'h00) begin
            r.comp = t.comp - 6'h01;
         end else if (t.mult != 4'h0) begin
            r.mult = t.mult - 4'h1;
            r.comp = 6'h3F;
         end
      end
      return r;
   endfunction : tune_step

   // ----------------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------------
   logic [1:0] code_now;
   logic [15:0] target;
   logic [15:0] band;
   logic cnt_hi;
   logic cnt_lo;
   logic ap_valid;
   logic blk_touch;
   logic show_prox;
   logic show_t0;
   logic show_t1;

   always_comb begin
      st_d = st_q;
      st_d.conv_req = 1'b0;

      // fast rate if unconfigured or zoomed, else the selected mode
      code_now = (st_q.fast || !st_q.cfg) ? CSS_FAST_RATE_MODE : st_q.mode;

      // zoom to the fast rate; each undebounced event restarts the hold
      if (suspect_i) begin
         st_d.fast = 1'b1;
         st_d.hold_cnt = 32'h0000_0000;
      end else if (st_q.fast) begin
         if (st_q.hold_cnt >= 32'(HOLD_CYC - 1)) begin
            st_d.fast = 1'b0;
            st_d.hold_cnt = 32'h0000_0000;
         end else begin
            st_d.hold_cnt = st_q.hold_cnt + 32'h0000_0001;
         end
      end

      // period timer restarts from zero whenever the active rate changes
      if (code_now != st_q.rate_code) begin
         st_d.rate_code = code_now;
         st_d.per_cnt = 32'h0000_0000;
      end else if (st_q.per_cnt >= period_of(code_now) - 32'h0000_0001) begin
         st_d.per_cnt = 32'h0000_0000;
         st_d.round_pend = 1'b1;
      end else begin
         st_d.per_cnt = st_q.per_cnt + 32'h0000_0001;
      end

      // count evaluation against target and band of the current slot channel
      if (st_q.conv_ch == 2'h0) begin
         target = st_q.tgt_low ? `CSS_TGT_PROX_LOW : `CSS_TGT_PROX_DEF;
      end else begin
         target = st_q.tgt_low ? `CSS_TGT_TOUCH_LOW : `CSS_TGT_TOUCH_DEF;
      end
      band = st_q.tgt_low ? `CSS_BAND_LOW : `CSS_BAND_DEF;
      cnt_hi = count_i > (target + band);
      cnt_lo = count_i < (target - band);

      // slot sequencer: proximity ahead of each touch channel
      case (st_q.seq)
         CSS_IDLE: begin
            if (st_q.round_pend) begin
               st_d.round_pend = st_d.per_cnt == 32'h0000_0000 && code_now == st_q.rate_code
                  && st_q.per_cnt != 32'h0000_0000;
               st_d.seq = CSS_PROX_A;
               st_d.conv_req = 1'b1;
               st_d.conv_ch = 2'h0;
               st_d.join_sw = 1'b1;
            end
         end
         CSS_PROX_A, CSS_TOUCH_A, CSS_PROX_B, CSS_TOUCH_B: begin
            if (conv_done_i) begin
               if (st_q.tuning) begin
                  st_d.tuned[st_q.conv_ch] = !(cnt_hi || cnt_lo);
                  if (cnt_hi || cnt_lo) begin
                     st_d.tune[st_q.conv_ch] = tune_step(st_q.tune[st_q.conv_ch], cnt_hi);
                  end
               end else if (cnt_hi || cnt_lo) begin
                  st_d.retune_pend = 1'b1;
               end
               st_d.join_sw = 1'b0;
               st_d.conv_req = 1'b1;
               case (st_q.seq)
                  CSS_PROX_A: begin
                     st_d.seq = CSS_TOUCH_A;
                     st_d.conv_ch = 2'h1;
                  end
                  CSS_TOUCH_A: begin
                     st_d.seq = CSS_PROX_B;
                     st_d.conv_ch = 2'h0;
                     st_d.join_sw = 1'b1;
                  end
                  CSS_PROX_B: begin
                     st_d.seq = CSS_TOUCH_B;
                     st_d.conv_ch = 2'h2;
                  end
                  default: begin
                     st_d.seq = CSS_IDLE;
                     st_d.conv_req = 1'b0;
                     st_d.conv_ch = 2'h0;
                     // tuning ends after a full round with every channel in band
                     if (st_q.tuning && (&st_d.tuned)) begin
                        st_d.tuning = 1'b0;
                     end
                  end
               endcase
            end
         end
         default: begin
            st_d.seq = CSS_IDLE;
            st_d.join_sw = 1'b0;
         end
      endcase

      // retune start: at once, or after the proximity detect input has stayed clear
      if (st_q.retune_pend && !st_q.tuning) begin
         if (!st_q.delay_sel || st_q.dly_cnt >= 32'(TUNE_DELAY_CYC - 1)) begin
            st_d.tuning = 1'b1;
            st_d.tuned = 3'b000;
            st_d.retune_pend = 1'b0;
            st_d.dly_cnt = 32'h0000_0000;
         end else if (prox_det_i) begin
            st_d.dly_cnt = 32'h0000_0000;
         end else begin
            st_d.dly_cnt = st_q.dly_cnt + 32'h0000_0001;
         end
      end

      // output gating: tuning and noise silence all, guard blocks the other touch
      show_prox = prox_det_i && !st_q.tuning && !noise_i;
      show_t0 = touch_det_i[0] && !st_q.tuning && !noise_i;
      blk_touch = st_q.guard && touch_det_i[0] && !st_q.tuning;
      show_t1 = touch_det_i[1] && !st_q.tuning && !noise_i && !blk_touch;
      // active low pulls the pin down only while asserted, otherwise released
      if (st_q.act_low) begin
         st_d.pins.prox = 1'b0;
         st_d.pins.prox_oe = show_prox;
         st_d.pins.touch = 2'b00;
         st_d.pins.touch_oe = {show_t1, show_t0};
      end else begin
         st_d.pins.prox = show_prox;
         st_d.pins.prox_oe = 1'b1;
         st_d.pins.touch = {show_t1, show_t0};
         st_d.pins.touch_oe = 2'b11;
      end

      // bus: writes land in the data phase, word-size writes only
      ap_valid = hsel_i && htrans_i[1] && hready_i;
      if (st_q.ap_wr && st_q.ap_addr == `CSS_OFS_CTRL) begin
         st_d.mode = css_mode_e'(hwdata_i[`CSS_CTRL_MODE_LSB +: 2]);
         st_d.cfg = hwdata_i[`CSS_CTRL_CFG_BIT];
         st_d.guard = hwdata_i[`CSS_CTRL_GUARD_BIT];
         st_d.act_low = hwdata_i[`CSS_CTRL_ACTLOW_BIT];
         st_d.delay_sel = hwdata_i[`CSS_CTRL_DELAY_BIT];
         st_d.tgt_low = hwdata_i[`CSS_CTRL_TGTLOW_BIT];
      end
      st_d.ap_wr = ap_valid && hwrite_i && hsize_i == 3'h2;
      st_d.ap_addr = haddr_i[7:0];
      st_d.hreadyout = 1'b1;
      // read data taken after any write in flight, so back-to-back reads see it
      if (ap_valid && !hwrite_i) begin
         case (haddr_i[7:0])
            `CSS_OFS_CTRL: st_d.hrdata = {25'h0000000, st_d.tgt_low, st_d.delay_sel,
               st_d.act_low, st_d.guard, st_d.cfg, st_d.mode};
            `CSS_OFS_STATUS: st_d.hrdata = {16'h0000, st_q.seq, st_q.rate_code,
               st_q.pins.touch_oe, st_q.pins.touch, st_q.pins.prox_oe, st_q.pins.prox,
               st_q.retune_pend, st_q.tuning, st_q.fast};
            `CSS_OFS_TUNE: st_d.hrdata = {2'h0, st_q.tune};
            default: st_d.hrdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------------
   // tuning is armed at reset so the first rounds tune the electrodes
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_q <= '0;
         st_q.seq <= CSS_IDLE;
         {st_q.tgt_low, st_q.delay_sel, st_q.act_low, st_q.guard, st_q.cfg, st_q.mode}
            <= `CSS_CTRL_RESET;
         st_q.tuning <= 1'b1;
         st_q.tune <= {3{`CSS_MULT_RESET, `CSS_COMP_RESET}};
         st_q.hreadyout <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------------------
   assign hrdata_o = st_q.hrdata;
   assign hreadyout_o = st_q.hreadyout;
   assign hresp_o = st_q.ap_wr & 1'b0; // always OKAY
   assign conv_req_o = st_q.conv_req;
   assign conv_ch_o = st_q.conv_ch;
   assign join_sw_o = st_q.join_sw;
   assign tune_o = st_q.tune;
   assign prox_o = st_q.pins.prox;
   assign prox_oe_o = st_q.pins.prox_oe;
   assign touch_o = st_q.pins.touch;
   assign touch_oe_o = st_q.pins.touch_oe;
   assign fast_o = st_q.fast;
   assign tuning_o = st_q.tuning;

endmodule : css_capacitive_sense_scheduler
`default_nettype wire

// file: rtl/css_params.svh
// constants of the capacitive sense scheduler: offsets, fields, resets, timing
`ifndef CSS_PARAMS_SVH
`define CSS_PARAMS_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CSS_CLK_HZ 10000000
`define CSS_CYC_PER_MS (`CSS_CLK_HZ / 1000)
`define CSS_PERIOD_FAST_MS 9
`define CSS_PERIOD_NORMAL_MS 32
`define CSS_PERIOD_SLOW1_MS 128
`define CSS_PERIOD_SLOW2_MS 1000
`define CSS_HOLD_S 5
`define CSS_TUNE_DELAY_S 10
`define CSS_CYC_PER_S `CSS_CLK_HZ

// ----------------------------------------------------------------------------
// tuning targets and band
// ----------------------------------------------------------------------------
`define CSS_TGT_PROX_DEF 16'h03E8
`define CSS_TGT_TOUCH_DEF 16'h01F4
`define CSS_TGT_PROX_LOW 16'h01F4
`define CSS_TGT_TOUCH_LOW 16'h00FA
`define CSS_BAND_DEF 16'h00A0
`define CSS_BAND_LOW 16'h0050

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define CSS_OFS_CTRL 8'h00
`define CSS_OFS_STATUS 8'h04
`define CSS_OFS_TUNE 8'h08

// ----------------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------------
`define CSS_CTRL_MODE_LSB 0
`define CSS_CTRL_CFG_BIT 2
`define CSS_CTRL_GUARD_BIT 3
`define CSS_CTRL_ACTLOW_BIT 4
`define CSS_CTRL_DELAY_BIT 5
`define CSS_CTRL_TGTLOW_BIT 6
`define CSS_CTRL_RESET 7'h00
`define CSS_MULT_RESET 4'h8
`define CSS_COMP_RESET 6'h20

`endif

// file: rtl/css_pkg.sv
// types shared by the capacitive sense scheduler
package css_pkg;

   // ----------------------------------------------------------------------------
   // power modes and slot sequencer
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0] {
      CSS_FAST_RATE_MODE = 2'h0,
      CSS_NORMAL_RATE_MODE = 2'h1,
      CSS_SLOW_RATE_MODE_ONE = 2'h2,
      CSS_SLOW_RATE_MODE_TWO = 2'h3
   } css_mode_e;

   typedef enum logic [4:0] {
      CSS_IDLE = 5'b00001,
      CSS_PROX_A = 5'b00010,
      CSS_TOUCH_A = 5'b00100,
      CSS_PROX_B = 5'b01000,
      CSS_TOUCH_B = 5'b10000
   } css_seq_e;

   // coarse and fine tuning of one channel
   typedef struct packed {
      logic [3:0] mult;
      logic [5:0] comp;
   } css_tune_s;

   // direct outputs toward the host: level and enable per pin
   typedef struct packed {
      logic prox;
      logic prox_oe;
      logic [1:0] touch;
      logic [1:0] touch_oe;
   } css_pins_s;

   typedef struct packed {
      css_seq_e seq;
      css_mode_e mode;
      logic cfg;
      logic guard;
      logic act_low;
      logic delay_sel;
      logic tgt_low;
      logic fast;
      logic [1:0] rate_code;
      logic [31:0] hold_cnt;
      logic [31:0] per_cnt;
      logic round_pend;
      logic conv_req;
      logic [1:0] conv_ch;
      logic join_sw;
      logic tuning;
      logic [2:0] tuned;
      logic retune_pend;
      logic [31:0] dly_cnt;
      css_tune_s [2:0] tune;
      css_pins_s pins;
      logic ap_wr;
      logic [7:0] ap_addr;
      logic [31:0] hrdata;
      logic hreadyout;
   } css_state_s;

endpackage : css_pkg

// file: tb/capacitive_sense_scheduler_bench.sv
// self-checking testbench of the capacitive sense scheduler
`timescale 1ns/10ps
`default_nettype none
module capacitive_sense_scheduler_bench;
   localparam int PF = 40, PN = 60, P1 = 80, P2 = 100, HOLD = 400, DLY = 300;
   typedef struct {string nm; int src; logic [31:0] m; logic [31:0] e;} css_exp_s;
   logic clk_i = 0, resetn_i = 0, hsel_i = 0, hwrite_i = 0, hready_i, suspect_i = 0;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o;
   logic [1:0] htrans_i = 0, conv_ch_o, touch_det_i = 2'h3, touch_o, touch_oe_o;
   logic [2:0] hsize_i = 3'b010, lag = 3'h1;
   logic hreadyout_o, hresp_o, conv_req_o, join_sw_o, conv_done_i, prox_det_i = 1, noise_i = 0;
   logic prox_o, prox_oe_o, fast_o, tuning_o, tlow = 0, off = 0, g, al, nz, pd;
   logic [15:0] count_i;
   logic [29:0] tune_o;
   logic [1:0] td, t;
   int mismatches = 0, compares = 0, cyc = 0, since = 0, gap = 0, n, seed = 32747;
   int per[4] = '{PF, PN, P1, P2};
   css_exp_s expq[$];
   logic [2:0] chq[$];
   logic [1:0] last_ch = 2'h2;
   event got, rs;
   css_capacitive_sense_scheduler #(.PERIOD_FAST_CYC(PF), .PERIOD_NORMAL_CYC(PN),
      .PERIOD_SLOW1_CYC(P1), .PERIOD_SLOW2_CYC(P2), .HOLD_CYC(HOLD), .TUNE_DELAY_CYC(DLY)) dut (.*);
   // single slave on the bus: its ready is the bus ready
   assign hready_i = hreadyout_o;
   css_front_model u_front (.clk_i(clk_i), .resetn_i(resetn_i), .conv_req_i(conv_req_o),
      .conv_ch_i(conv_ch_o), .lag_i(lag), .tgt_low_i(tlow), .off_band_i(off),
      .conv_done_o(conv_done_i), .count_o(count_i));
   always #50 clk_i = ~clk_i;
   // ----------------------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // hang guard: generous against the whole sequence
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   // takes the oldest note when a result appears and compares it
   always @(got) begin
      css_exp_s x;
      logic [31:0] v;
      x = expq.pop_front();
      case (x.src)
         0: v = hrdata_o;
         1: v = {24'h0, fast_o, tuning_o, prox_o, prox_oe_o, touch_o, touch_oe_o};
         2: v = gap;
         default: v = {31'h0, tune_o[9:0] != 10'h220};
      endcase
      check(x.nm, v & x.m, x.e);
   end
   // the first 80 requests against the slot order; spacing of round starts
   always @(posedge clk_i) begin
      since++;
      if (conv_req_o === 1'b1) begin
         if (chq.size() > 0) check("slot", {conv_ch_o, join_sw_o}, chq.pop_front());
         if (conv_ch_o == 2'h0 && last_ch == 2'h2) begin
            gap = since;
            since = 0;
            ->rs;
         end
         last_ch = conv_ch_o;
      end
   end
   // ----------------------------------------------------------------------------
   // drivers: one master on the bus, results noted in order
   // ----------------------------------------------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      @(posedge clk_i);
      while (hreadyout_o !== 1'b1) @(posedge clk_i);
   endtask : bus
   task automatic note(input string nm, input int s, input logic [31:0] m, input logic [31:0] e);
      expq.push_back('{nm, s, m, e});
      if (s == 0) bus(1'b0, e[31:24], 32'h0);
      else @(negedge clk_i);
      ->got;
   endtask : note
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      expq.push_back('{nm, 0, 32'hFFFFFFFF, e});
      bus(1'b0, a, 32'h0);
      ->got;
   endtask : rd
   task automatic spacing(input string nm, input int p);
      @(rs);
      @(rs);
      note(nm, 2, 32'hFFFF, p);
   endtask : spacing
   task automatic wait_tune(input logic v, input int lim);
      for (n = 0; n < lim && tuning_o !== v; n++) @(posedge clk_i);
   endtask : wait_tune
   initial begin
      repeat (10) @(posedge clk_i);
      resetn_i <= 1'b1;
      // pin enables come up only at the first edge after release
      @(posedge clk_i);
      for (int i = 0; i < 80; i++) chq.push_back(i % 4 == 1 ? 3'h2 : i % 4 == 3 ? 3'h4 : 3'h1);
      note("pins quiet while tuning", 1, 32'h7F, 32'h53);
      rd("ctrl reset", 8'h00, 32'h0);
      rd("tune reset", 8'h08, {3{10'h220}});
      rd("status reset", 8'h04, 32'h0992);
      bus(1'b1, 8'h10, 32'hFFFFFFFF);
      rd("unmapped", 8'h10, 32'h0);
      hsize_i <= 3'h0;
      bus(1'b1, 8'h00, 32'h7F);
      hsize_i <= 3'h2;
      rd("byte write refused", 8'h00, 32'h0);
      wait_tune(1'b0, 2000);
      note("start tuning done", 1, 32'h40, 32'h0);
      $display("test reset done");
      spacing("unconfigured", PF);
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, 8'h00, 32'h4 | m);
         spacing("mode period", per[m]);
      end
      bus(1'b1, 8'h00, 32'h3);
      spacing("cfg off", PF);
      $display("test rates done");
      bus(1'b1, 8'h00, 32'h7);
      spacing("slow two", P2);
      repeat ({$random(seed)} % 20) @(posedge clk_i);
      suspect_i <= 1'b1;
      @(posedge clk_i);
      suspect_i <= 1'b0;
      note("zoom on", 1, 32'h80, 32'h80);
      spacing("zoom rate", PF);
      repeat (HOLD - 100) @(posedge clk_i);
      suspect_i <= 1'b1;
      @(posedge clk_i);
      suspect_i <= 1'b0;
      repeat (HOLD - 100) @(posedge clk_i);
      note("zoom extended", 1, 32'h80, 32'h80);
      repeat (110) @(posedge clk_i);
      note("zoom over", 1, 32'h80, 32'h0);
      spacing("back to mode", P2);
      $display("test zoom done");
      for (int k = 0; k < 16; k++) begin
         {nz, al, g} = k[2:0];
         {td, pd} = k[3] ? 3'h7 : $random(seed);
         bus(1'b1, 8'h00, {27'h0, al, g, 3'h4});
         lag <= 3'h1 + 3'({$random(seed)} % 4);
         noise_i <= nz;
         prox_det_i <= pd;
         touch_det_i <= td;
         repeat (2) @(posedge clk_i);
         t = td & ~{2{nz}};
         if (g && t[0]) t[1] = 1'b0;
         note("pins", 1, 32'h3F, al ? {2'b00, pd & ~nz, 2'b00, t} : {pd & ~nz, 1'b1, t, 2'b11});
      end
      noise_i <= 1'b0;
      prox_det_i <= 1'b0;
      touch_det_i <= 2'h0;
      $display("test pins done");
      bus(1'b1, 8'h00, 32'h44);
      tlow <= 1'b1;
      off <= 1'b1;
      wait_tune(1'b1, 3 * PF);
      note("retune now", 1, 32'h40, 32'h40);
      // keep counts off band for two round periods so the tuning steps really move
      repeat (2 * PF) @(posedge clk_i);
      off <= 1'b0;
      wait_tune(1'b0, 2000);
      note("low target tuned", 1, 32'h40, 32'h0);
      note("tune moved", 3, 32'h1, 32'h1);
      bus(1'b1, 8'h00, 32'h64);
      prox_det_i <= 1'b1;
      off <= 1'b1;
      repeat (3 * PF) @(posedge clk_i);
      note("held by prox", 1, 32'h40, 32'h0);
      prox_det_i <= 1'b0;
      wait_tune(1'b1, DLY + 3 * PF);
      note("delayed retune", 1, 32'h40, 32'h40);
      check("retune delay", 32'(n >= DLY - 5 && n <= DLY + 5), 32'h1);
      off <= 1'b0;
      wait_tune(1'b0, 2000);
      note("retune ends", 1, 32'h40, 32'h0);
      $display("test retune done");
      print_verdict();
   end
endmodule : capacitive_sense_scheduler_bench
`default_nettype wire

// file: tb/css_asserts.sv
// checker: port-level assertions of the capacitive sense scheduler
`timescale 1ns/10ps
`default_nettype none
module css_asserts #(
   parameter int unsigned HOLD_CYC = 400
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic conv_req_o,
   input wire logic [1:0] conv_ch_o,
   input wire logic join_sw_o,
   input wire logic suspect_i,
   input wire logic noise_i,
   input wire logic prox_o,
   input wire logic [1:0] touch_o,
   input wire logic fast_o,
   input wire logic tuning_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic [31:0] quiet_q;
   logic [1:0] last_ch_q;
   logic [1:0] last_t_q;
   // ----------------------------------------------------------------------------
   // helpers: quiet cycles since a suspect, last channels requested
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         quiet_q <= 32'h0;
         last_ch_q <= 2'h2;
         last_t_q <= 2'h2;
      end else begin
         quiet_q <= suspect_i ? 32'h0 : quiet_q + 32'h1;
         if (conv_req_o) last_ch_q <= conv_ch_o;
         if (conv_req_o && conv_ch_o != 2'h0) last_t_q <= conv_ch_o;
      end
   end
   a_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or not okay");
   a_req_single: assert property (conv_req_o |=> !conv_req_o)
      else $error("request longer than one cycle");
   a_join_prox: assert property (conv_req_o |-> join_sw_o == (conv_ch_o == 2'h0))
      else $error("electrode join wrong for slot");
   a_touch_order: assert property (conv_req_o && conv_ch_o != 2'h0 |->
      last_ch_q == 2'h0 && conv_ch_o != last_t_q) else $error("slot order broken");
   a_noise_block: assert property (noise_i |=> !prox_o && touch_o == 2'h0)
      else $error("output active under noise");
   a_tune_quiet: assert property (tuning_o |=> !prox_o && touch_o == 2'h0)
      else $error("event reported while tuning");
   a_zoom_on: assert property (suspect_i |=> fast_o) else $error("no zoom on suspect");
   a_zoom_keep: assert property ($fell(suspect_i) |-> fast_o [*8])
      else $error("zoom dropped right after suspect");
   a_hold_min: assert property ($fell(fast_o) |-> quiet_q == HOLD_CYC)
      else $error("zoom length differs from hold time");
endmodule : css_asserts
bind css_capacitive_sense_scheduler css_asserts #(.HOLD_CYC(HOLD_CYC)) u_asserts (
   .clk_i(clk_i), .resetn_i(resetn_i), .conv_req_o(conv_req_o), .conv_ch_o(conv_ch_o),
   .join_sw_o(join_sw_o), .suspect_i(suspect_i), .noise_i(noise_i), .prox_o(prox_o),
   .touch_o(touch_o), .fast_o(fast_o), .tuning_o(tuning_o), .hreadyout_o(hreadyout_o),
   .hresp_o(hresp_o));
`default_nettype wire

// file: tb/css_front_model.sv
// behavioural model of the sense front end answering conversion requests
`timescale 1ns/10ps
`default_nettype none
module css_front_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic conv_req_i,
   input wire logic [1:0] conv_ch_i,
   input wire logic [2:0] lag_i,
   input wire logic tgt_low_i,
   input wire logic off_band_i,
   output logic conv_done_o,
   output logic [15:0] count_o
);
   logic [2:0] wait_q;
   logic busy_q;
   logic [1:0] ch_q;
   logic [15:0] tgt;
   // count lands on the channel target, or far off it when the bench asks
   always_comb begin
      tgt = (ch_q == 2'h0) ? 16'h03E8 : 16'h01F4;
      if (tgt_low_i) tgt = tgt >> 1;
      if (off_band_i) tgt = tgt + 16'h0190;
   end
   // answer after lag cycles; count is scrambled outside the done strobe
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_q <= 1'b0;
         wait_q <= 3'h0;
         ch_q <= 2'h0;
         conv_done_o <= 1'b0;
         count_o <= 16'h0;
      end else begin
         conv_done_o <= 1'b0;
         count_o <= ~count_o;
         if (conv_req_i) begin
            busy_q <= 1'b1;
            wait_q <= lag_i;
            ch_q <= conv_ch_i;
         end else if (busy_q && wait_q <= 3'h1) begin
            busy_q <= 1'b0;
            conv_done_o <= 1'b1;
            count_o <= tgt;
         end else if (busy_q) begin
            wait_q <= wait_q - 3'h1;
         end
      end
   end
endmodule : css_front_model
`default_nettype wire
